/* core/addr_match_regs.vh */
// Constants for the ROM patch address match jump block.
// Assumes register indices are multiplied by four to form AXI byte addresses.
`ifndef ADDR_MATCH_REGS_VH
`define ADDR_MATCH_REGS_VH

// Register indices, one byte-wide register per aligned 32-bit word
`define IDX_SET0_LOW 16'hff70
`define IDX_SET0_HIGH 16'hff71
`define IDX_SET1_LOW 16'hff72
`define IDX_SET1_HIGH 16'hff73
`define IDX_SET2_LOW 16'hff74
`define IDX_SET2_HIGH 16'hff75
`define IDX_SET3_LOW 16'hff76
`define IDX_SET3_HIGH 16'hff77
`define IDX_CTRL 16'hff78
`define IDX_STATUS 16'hff79

// Widths and set count
`define ADDR_W 18
`define IDX_W 16
`define NUM_SETS 4

// Reset values
`define RST_MATCH_BYTE 8'h00
`define RST_CTRL 8'h01

// Fixed indirect vector locations per set
`define VEC_SET0 8'h2a
`define VEC_SET1 8'h2c
`define VEC_SET2 8'h2e
`define VEC_SET3 8'h30

// Control register fields
`define CTRL_ENABLE_BIT 0

// Status register fields
`define STAT_ENABLED_LSB 0
`define STAT_LAST_SET_LSB 4
`define STAT_HIT_BIT 6
`define STAT_EXT_MODE_BIT 7

// AXI responses
`define RESP_OKAY 2'h0
`define RESP_SLVERR 2'h2

`endif

/* core/axil_byte_slave.v */
// AXI4-Lite slave front end that turns bus transfers into byte register strobes.
// Assumes one clock, synchronous active-low reset, and a decoder that answers
// whether an index is mapped in the same cycle.
`timescale 1ns/1ps
`default_nettype none
`include "addr_match_regs.vh"

module axil_byte_slave (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // Write address channel
    input wire [`ADDR_W-1:0] awaddr,
    input wire awvalid,
    output wire awready,
    // Write data channel
    input wire [31:0] wdata,
    input wire [3:0] wstrb,
    input wire wvalid,
    output wire wready,
    // Write response channel
    output reg [1:0] bresp,
    output reg bvalid,
    input wire bready,
    // Read address channel
    input wire [`ADDR_W-1:0] araddr,
    input wire arvalid,
    output wire arready,
    // Read data channel
    output reg [31:0] rdata,
    output reg [1:0] rresp,
    output reg rvalid,
    input wire rready,
    // Register side
    output wire wr_en,
    output wire [`IDX_W-1:0] wr_index,
    output wire [7:0] wr_data,
    input wire wr_mapped,
    output wire [`IDX_W-1:0] rd_index,
    input wire [7:0] rd_data,
    input wire rd_mapped
);

reg aw_held_ff;
reg w_held_ff;
reg [`IDX_W-1:0] aw_index_ff;
reg [7:0] w_byte_ff;
reg w_lane_ff;

// Address and data are taken independently, in either order
assign awready = !aw_held_ff && !bvalid;
assign wready = !w_held_ff && !bvalid;
assign wr_en = aw_held_ff && w_held_ff && !bvalid && w_lane_ff;
assign wr_index = aw_index_ff;
assign wr_data = w_byte_ff;
assign arready = !rvalid;
assign rd_index = araddr[`ADDR_W-1:2];

// Write path: hold both halves, store, then answer
always @(posedge aclk) begin
    if (!aresetn) begin
        aw_held_ff <= 1'b0;
        w_held_ff <= 1'b0;
        aw_index_ff <= 16'h0000;
        w_byte_ff <= 8'h00;
        w_lane_ff <= 1'b0;
        bvalid <= 1'b0;
        bresp <= `RESP_OKAY;
    end else begin
        if (awvalid && awready) begin
            aw_held_ff <= 1'b1;
            aw_index_ff <= awaddr[`ADDR_W-1:2];
        end
        if (wvalid && wready) begin
            w_held_ff <= 1'b1;
            w_byte_ff <= wdata[7:0];
            w_lane_ff <= wstrb[0];  // Upper lanes hold nothing
        end
        if (aw_held_ff && w_held_ff && !bvalid) begin
            aw_held_ff <= 1'b0;
            w_held_ff <= 1'b0;
            bvalid <= 1'b1;
            bresp <= wr_mapped ? `RESP_OKAY : `RESP_SLVERR;
        end else if (bvalid && bready) begin
            bvalid <= 1'b0;
        end
    end
end

// Read path: data captured when the address is taken
always @(posedge aclk) begin
    if (!aresetn) begin
        rvalid <= 1'b0;
        rdata <= 32'h00000000;
        rresp <= `RESP_OKAY;
    end else if (arvalid && arready) begin
        rvalid <= 1'b1;
        rdata <= {24'h000000, rd_mapped ? rd_data : 8'h00};
        rresp <= rd_mapped ? `RESP_OKAY : `RESP_SLVERR;
    end else if (rvalid && rready) begin
        rvalid <= 1'b0;
    end
end

endmodule
`default_nettype wire

/* core/match_compare.v */
// Four-way comparator of an opcode fetch address against the match values.
// Assumes match values arrive packed, set 0 in the low 16 bits.
`timescale 1ns/1ps
`default_nettype none
`include "addr_match_regs.vh"

module match_compare (
    // Programmed values
    input wire [16*`NUM_SETS-1:0] match_values,
    // Fetch address
    input wire [15:0] fetch_addr,
    // Results
    output wire [`NUM_SETS-1:0] set_enabled,
    output wire [`NUM_SETS-1:0] set_hit,
    output reg [1:0] first_set,
    output wire any_hit
);

genvar gi;
generate
    for (gi = 0; gi < `NUM_SETS; gi = gi + 1) begin : g_set
        // All-zero value means the set is off
        assign set_enabled[gi] = |match_values[16*gi+15:16*gi];
        // Plain equality; no check of what byte lies there
        assign set_hit[gi] = set_enabled[gi] &&
            (match_values[16*gi+15:16*gi] == fetch_addr);
    end
endgenerate

assign any_hit = |set_hit;

// Lowest numbered hit wins
always @* begin
    if (set_hit[0])
        first_set = 2'h0;
    else if (set_hit[1])
        first_set = 2'h1;
    else if (set_hit[2])
        first_set = 2'h2;
    else
        first_set = 2'h3;
end

endmodule
`default_nettype wire

/* core/rom_patch_jump.v */
// ROM patch address match jump: four match sets, AXI4-Lite register access,
// and a forced indirect jump request toward the CPU fetch path.
// Assumes the core presents each opcode fetch address with a one-cycle
// qualifier and accepts the jump request one cycle later.
//
// Contract
// - Four 16-bit match registers, low byte at the even index, high at the odd, set 0 lowest.
// - Set 3 sits in the last pair, sets 1 and 2 in ascending order between.
// - An opcode fetch from a set's match address forces an indirect jump through its vector.
// - Vectors are fixed: set 0 at 2a, set 1 at 2c, set 2 at 2e, set 3 at 30.
// - A set whose match value is zero is disabled and never jumps.
// - Reset clears all four match values, so every set starts disabled.
// - No check is made of what kind of byte the matched address holds.
// - No forced jump is issued in external processor mode.
// - The vector is a logical address in the current bank; the bank never changes.
`timescale 1ns/1ps
`default_nettype none
`include "addr_match_regs.vh"

module rom_patch_jump (
    // Clock and reset
    input wire aclk,
    input wire aresetn,

    // AXI4-Lite write address
    input wire [`ADDR_W-1:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output wire s_axi_awready,

    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output wire s_axi_wready,

    // AXI4-Lite write response
    output wire [1:0] s_axi_bresp,
    output wire s_axi_bvalid,
    input wire s_axi_bready,

    // AXI4-Lite read address
    input wire [`ADDR_W-1:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output wire s_axi_arready,

    // AXI4-Lite read data
    output wire [31:0] s_axi_rdata,
    output wire [1:0] s_axi_rresp,
    output wire s_axi_rvalid,
    input wire s_axi_rready,

    // Chip mode
    input wire external_processor_mode,

    // CPU fetch path
    input wire [15:0] fetch_addr,
    input wire [7:0] fetch_bank,
    input wire fetch_opcode,

    // Forced jump toward the core
    output wire forced_indirect_jump,
    output wire [7:0] jump_vector,
    output wire [7:0] jump_bank,
    output wire [1:0] jump_set
);

// Bus side strobes
wire wr_en;
wire [`IDX_W-1:0] wr_index;
wire [7:0] wr_data;
wire [`IDX_W-1:0] rd_index;
reg [7:0] rd_data;
reg rd_mapped;
reg wr_mapped;

// Match storage, one byte pair per set
reg [7:0] match_low_ff [0:`NUM_SETS-1];
reg [7:0] match_high_ff [0:`NUM_SETS-1];
wire [16*`NUM_SETS-1:0] match_values;

// Control and status
reg [7:0] ctrl_ff;
reg hit_seen_ff;
reg nxt_hit_seen;
reg [1:0] last_set_ff;
reg mode_ext_ff;

// Compare results
wire [`NUM_SETS-1:0] set_enabled;
wire [`NUM_SETS-1:0] set_hit;
wire [1:0] first_set;
wire any_hit;

// Fetch stage outputs
reg jump_req_ff;
reg [7:0] vector_ff;
reg [7:0] bank_ff;
reg [1:0] set_ff;
wire jump_now;

// Register bus front end
axil_byte_slave u_bus (
    .aclk(aclk),
    .aresetn(aresetn),
    .awaddr(s_axi_awaddr),
    .awvalid(s_axi_awvalid),
    .awready(s_axi_awready),
    .wdata(s_axi_wdata),
    .wstrb(s_axi_wstrb),
    .wvalid(s_axi_wvalid),
    .wready(s_axi_wready),
    .bresp(s_axi_bresp),
    .bvalid(s_axi_bvalid),
    .bready(s_axi_bready),
    .araddr(s_axi_araddr),
    .arvalid(s_axi_arvalid),
    .arready(s_axi_arready),
    .rdata(s_axi_rdata),
    .rresp(s_axi_rresp),
    .rvalid(s_axi_rvalid),
    .rready(s_axi_rready),
    .wr_en(wr_en),
    .wr_index(wr_index),
    .wr_data(wr_data),
    .wr_mapped(wr_mapped),
    .rd_index(rd_index),
    .rd_data(rd_data),
    .rd_mapped(rd_mapped)
);

// Comparator bank
match_compare u_cmp (
    .match_values(match_values),
    .fetch_addr(fetch_addr),
    .set_enabled(set_enabled),
    .set_hit(set_hit),
    .first_set(first_set),
    .any_hit(any_hit)
);

// Fixed vector per set, never programmable
function [7:0] set_vector;
    input [1:0] set_num;
    begin
        case (set_num)
            2'h0: set_vector = `VEC_SET0;
            2'h1: set_vector = `VEC_SET1;
            2'h2: set_vector = `VEC_SET2;
            2'h3: set_vector = `VEC_SET3;
            default: set_vector = `VEC_SET0;
        endcase
    end
endfunction

// Per-set storage; the even index is the low byte
genvar gi;
generate
    for (gi = 0; gi < `NUM_SETS; gi = gi + 1) begin : g_store
        wire [`IDX_W-1:0] low_idx;
        wire [`IDX_W-1:0] high_idx;
        wire [31:0] low_sum;
        wire [31:0] high_sum;
        // Pairs rise from set 0 to set 3; integer sums cut back to index width
        assign low_sum = `IDX_SET0_LOW + (gi * 2);
        assign high_sum = `IDX_SET0_HIGH + (gi * 2);
        assign low_idx = low_sum[`IDX_W-1:0];
        assign high_idx = high_sum[`IDX_W-1:0];
        assign match_values[16*gi+15:16*gi] = {match_high_ff[gi], match_low_ff[gi]};

        always @(posedge aclk) begin
            if (!aresetn) begin
                match_low_ff[gi] <= `RST_MATCH_BYTE;
                match_high_ff[gi] <= `RST_MATCH_BYTE;
            end else if (wr_en) begin
                // Bytes are written one at a time; a half-written pair can
                // match briefly, so software should patch with the set off
                if (wr_index == low_idx)
                    match_low_ff[gi] <= wr_data;
                if (wr_index == high_idx)
                    match_high_ff[gi] <= wr_data;
            end
        end
    end
endgenerate

// Write address decode
always @* begin
    case (wr_index)
        `IDX_SET0_LOW, `IDX_SET0_HIGH,
        `IDX_SET1_LOW, `IDX_SET1_HIGH,
        `IDX_SET2_LOW, `IDX_SET2_HIGH,
        `IDX_SET3_LOW, `IDX_SET3_HIGH,
        `IDX_CTRL, `IDX_STATUS: wr_mapped = 1'b1;
        default: wr_mapped = 1'b0;
    endcase
end

// Read mux; reserved bits of the control byte read zero
always @* begin
    rd_mapped = 1'b1;
    case (rd_index)
        `IDX_SET0_LOW: rd_data = match_low_ff[0];
        `IDX_SET0_HIGH: rd_data = match_high_ff[0];
        `IDX_SET1_LOW: rd_data = match_low_ff[1];
        `IDX_SET1_HIGH: rd_data = match_high_ff[1];
        `IDX_SET2_LOW: rd_data = match_low_ff[2];
        `IDX_SET2_HIGH: rd_data = match_high_ff[2];
        `IDX_SET3_LOW: rd_data = match_low_ff[3];
        `IDX_SET3_HIGH: rd_data = match_high_ff[3];
        `IDX_CTRL: rd_data = {7'h00, ctrl_ff[`CTRL_ENABLE_BIT]};
        `IDX_STATUS: rd_data = {mode_ext_ff, hit_seen_ff, last_set_ff, set_enabled};
        default: begin
            rd_data = 8'h00;
            rd_mapped = 1'b0;
        end
    endcase
end

// Control register: global enable, set at reset so the sets alone decide
always @(posedge aclk) begin
    if (!aresetn)
        ctrl_ff <= `RST_CTRL;
    else if (wr_en && wr_index == `IDX_CTRL)
        ctrl_ff <= {7'h00, wr_data[`CTRL_ENABLE_BIT]};
end

// Mode is a strap level; sampled each cycle, not caught in reset
always @(posedge aclk) begin
    if (!aresetn)
        mode_ext_ff <= 1'b0;
    else
        mode_ext_ff <= external_processor_mode;
end

// No jump while the core runs from outside memory
assign jump_now = fetch_opcode && any_hit && !external_processor_mode &&
    ctrl_ff[`CTRL_ENABLE_BIT];

// Sticky hit flag; a new hit beats a clear in the same cycle
always @* begin
    nxt_hit_seen = hit_seen_ff;
    if (wr_en && wr_index == `IDX_STATUS && wr_data[`STAT_HIT_BIT])
        nxt_hit_seen = 1'b0;
    if (jump_now)
        nxt_hit_seen = 1'b1;
end

// Status bookkeeping
always @(posedge aclk) begin
    if (!aresetn) begin
        hit_seen_ff <= 1'b0;
        last_set_ff <= 2'h0;
    end else begin
        hit_seen_ff <= nxt_hit_seen;
        if (jump_now)
            last_set_ff <= first_set;
    end
end

// Jump request, one cycle after the matching fetch
always @(posedge aclk) begin
    if (!aresetn) begin
        jump_req_ff <= 1'b0;
        vector_ff <= 8'h00;
        bank_ff <= 8'h00;
        set_ff <= 2'h0;
    end else begin
        jump_req_ff <= jump_now;
        if (jump_now) begin
            vector_ff <= set_vector(first_set);
            // Current bank passes through untouched
            bank_ff <= fetch_bank;
            set_ff <= first_set;
        end
    end
end

// Outputs toward the core
assign forced_indirect_jump = jump_req_ff;
assign jump_vector = vector_ff;
assign jump_bank = bank_ff;
assign jump_set = set_ff;

endmodule
`default_nettype wire

/* verification/rom_patch_jump_chk.sv */
// Checker for the ROM patch jump block: fetch side and bus answers.
// Assumes it is bound to the top module and sees only that module's ports.
`timescale 1ns/1ps
`default_nettype none
module rom_patch_jump_chk (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Bus answers
    input wire logic s_axi_arvalid,
    input wire logic s_axi_arready,
    input wire logic s_axi_rvalid,
    input wire logic s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic s_axi_bvalid,
    input wire logic s_axi_bready,
    input wire logic [1:0] s_axi_bresp,
    // Fetch path
    input wire logic external_processor_mode,
    input wire logic [7:0] fetch_bank,
    input wire logic fetch_opcode,
    input wire logic forced_indirect_jump,
    input wire logic [7:0] jump_vector,
    input wire logic [7:0] jump_bank,
    input wire logic [1:0] jump_set
);
    default clocking cb @(posedge aclk); endclocking
    default disable iff (!aresetn);

    // Jump only answers a qualified fetch one cycle earlier
    a_jump_cause: assert property (forced_indirect_jump |-> $past(fetch_opcode))
        else $error("jump without an opcode fetch");
    a_ext_blocks: assert property ($past(external_processor_mode) |-> !forced_indirect_jump)
        else $error("jump in external processor mode");
    a_vector_fixed: assert property (forced_indirect_jump |->
        jump_vector == 8'h2a + {5'h0, jump_set, 1'b0})
        else $error("vector does not fit set");
    a_bank_kept: assert property (forced_indirect_jump |-> jump_bank == $past(fetch_bank))
        else $error("bank changed by jump");
    // Past reset guard: the last reset edge still samples pre-reset values
    a_vector_held: assert property (!forced_indirect_jump && $past(aresetn) |->
        $stable(jump_vector) && $stable(jump_set))
        else $error("vector moved without jump");
    a_read_answer: assert property (s_axi_arvalid && s_axi_arready |=> s_axi_rvalid)
        else $error("read not answered next cycle");
    a_read_hold: assert property (s_axi_rvalid && !s_axi_rready |=>
        s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped early");
    a_write_hold: assert property (s_axi_bvalid && !s_axi_bready |=>
        s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped early");
    a_byte_data: assert property (s_axi_rvalid |-> s_axi_rdata[31:8] == 24'h0)
        else $error("upper read bits not zero");
endmodule

bind rom_patch_jump rom_patch_jump_chk u_chk (.aclk, .aresetn, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rvalid, .s_axi_rready, .s_axi_rdata, .s_axi_bvalid,
    .s_axi_bready, .s_axi_bresp, .external_processor_mode, .fetch_bank, .fetch_opcode,
    .forced_indirect_jump, .jump_vector, .jump_bank, .jump_set);
`default_nettype wire

/* verification/cpu_fetch_model.sv */
// Model of the CPU fetch path that feeds opcode fetches to the block.
// Assumes the bench calls fetch and samples the jump outputs itself.
`timescale 1ns/1ps
`default_nettype none
module cpu_fetch_model (
    // Clock
    input wire logic aclk,
    // Fetch path
    output logic [15:0] fetch_addr = 16'h5a5a,
    output logic [7:0] fetch_bank = 8'h00,
    output logic fetch_opcode = 1'b0
);
    bit busy = 0;

    // Lines wander between fetches so a stale address never looks valid
    always @(posedge aclk) begin
        if (!busy) begin
            fetch_addr <= ~fetch_addr + 16'h0013;
            fetch_bank <= ~fetch_bank;
        end
    end

    // One opcode fetch, only ever at the first byte of an instruction
    task automatic fetch(input logic [15:0] a, input logic [7:0] b);
        busy = 1;
        @(posedge aclk);
        fetch_opcode <= 1'b1;
        fetch_addr <= a;
        fetch_bank <= b;
        @(posedge aclk);
        fetch_opcode <= 1'b0;
        busy = 0;
    endtask
endmodule
`default_nettype wire

/* verification/rom_patch_jump_bench.sv */
// Self-checking bench: AXI4-Lite master, fetch model and random patch traffic.
// Assumes register byte address is four times the index.
`timescale 1ns/1ps
`default_nettype none
`include "addr_match_regs.vh"
module rom_patch_jump_bench;
    logic aclk = 0, aresetn = 0, external_processor_mode = 0;
    logic [`ADDR_W-1:0] s_axi_awaddr = 0, s_axi_araddr = 0;
    logic [31:0] s_axi_wdata = 0, rs = 32'h4323;
    logic [3:0] s_axi_wstrb = 0;
    logic s_axi_awvalid = 0, s_axi_wvalid = 0, s_axi_bready = 0;
    logic s_axi_arvalid = 0, s_axi_rready = 0;
    wire logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
    wire logic forced_indirect_jump, fetch_opcode;
    wire logic [1:0] s_axi_bresp, s_axi_rresp, jump_set;
    wire logic [31:0] s_axi_rdata;
    wire logic [7:0] jump_vector, jump_bank, fetch_bank;
    wire logic [15:0] fetch_addr;
    logic [15:0] mv [4] = '{default: 16'h0};
    int err_total = 0, samples_checked = 0, n;
    bit en = 1;
    logic [15:0] v;

    rom_patch_jump DUT (.aclk, .aresetn, .s_axi_awaddr, .s_axi_awvalid, .s_axi_awready,
        .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready, .s_axi_bresp,
        .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid, .s_axi_arready,
        .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
        .external_processor_mode, .fetch_addr, .fetch_bank, .fetch_opcode,
        .forced_indirect_jump, .jump_vector, .jump_bank, .jump_set);
    cpu_fetch_model u_cpu (.aclk, .fetch_addr, .fetch_bank, .fetch_opcode);

    // 40 MHz clock
    initial begin
        forever #12.5 aclk = ~aclk;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // Lowest enabled set holding the address wins; none in external mode
    function automatic logic [2:0] exp_set(input logic [15:0] a);
        exp_set = 3'h0;
        for (int s = 3; s >= 0; s--) begin
            if (mv[s] != 16'h0 && mv[s] == a) exp_set = {1'b1, s[1:0]};
        end
        if (external_processor_mode || !en) exp_set = 3'h0;
    endfunction

    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        samples_checked++;
        if (g !== e) begin
            err_total++;
            $display("CHECK FAILED t=%0t got=%h exp=%h", $time, g, e);
        end
    endtask

    task automatic finish_test;
        if (err_total == 0 && samples_checked > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    // Requests start after an edge; readies and answers are taken at the edge itself
    task automatic axw(input logic [15:0] i, input logic [7:0] d, input logic [3:0] st,
            input logic [1:0] er);
        bit ok;
        ok = 0;
        rs = lfsr(rs);
        @(posedge aclk);
        s_axi_awaddr <= {i, 2'b00};
        s_axi_wdata <= {rs[31:8], d};
        s_axi_wstrb <= st;
        s_axi_awvalid <= 1;
        s_axi_wvalid <= 1;
        s_axi_bready <= 1;
        for (int k = 0; k < 50 && !ok; k++) begin
            @(posedge aclk);
            if (s_axi_awready) s_axi_awvalid <= 0;
            if (s_axi_wready) s_axi_wvalid <= 0;
            ok = s_axi_bvalid;
            if (ok) begin
                s_axi_bready <= 0;
                chk(s_axi_bresp, er);
            end
        end
        if (!ok) begin
            chk(32'h0, 32'h1);
            finish_test();
        end
    endtask

    task automatic axr(input logic [15:0] i, input logic [1:0] er, input logic [31:0] ed);
        bit ok;
        ok = 0;
        @(posedge aclk);
        s_axi_araddr <= {i, 2'b00};
        s_axi_arvalid <= 1;
        s_axi_rready <= 1;
        for (int k = 0; k < 50 && !ok; k++) begin
            @(posedge aclk);
            if (s_axi_arready) s_axi_arvalid <= 0;
            ok = s_axi_rvalid;
            if (ok) begin
                s_axi_rready <= 0;
                chk(s_axi_rresp, er);
                chk(s_axi_rdata, ed);
            end
        end
        if (!ok) begin
            chk(32'h0, 32'h1);
            finish_test();
        end
    endtask

    // Low byte at the even index, high byte at the odd one, set 0 lowest
    task automatic setv(input logic [1:0] s, input logic [15:0] v);
        axw(16'hff70 + 2 * s, v[7:0], 4'h1, 2'h0);
        axw(16'hff71 + 2 * s, v[15:8], 4'h1, 2'h0);
        mv[s] = v;
    endtask

    task automatic rall;
        for (int k = 0; k < 8; k++) begin
            axr(16'hff70 + k, 2'h0, k[0] ? mv[k / 2][15:8] : mv[k / 2][7:0]);
        end
    endtask

    task automatic fc(input logic [15:0] a);
        logic [2:0] e;
        logic [7:0] b;
        rs = lfsr(rs);
        b = rs[7:0];
        u_cpu.fetch(a, b);
        #1;
        e = exp_set(a);
        chk(forced_indirect_jump, e[2]);
        if (e[2]) begin
            chk(jump_set, e[1:0]);
            chk(jump_vector, 8'h2a + {e[1:0], 1'b0});
            chk(jump_bank, b);
        end
    endtask

    // Main sequence
    initial begin
        repeat (12) @(posedge aclk);
        aresetn <= 1;
        rall();
        axr(16'hff7a, 2'h2, 32'h0);
        axw(16'hff7a, 8'h5a, 4'h1, 2'h2);
        fc(16'h0000);
        for (int s = 0; s < 4; s++) begin
            rs = lfsr(rs);
            v = rs[15:0] | 16'h1;
            setv(s, v);
            rall();
            fc(v);
            setv(s, 16'h0);
            fc(v);
        end
        for (int s = 0; s < 4; s++) setv(s, 16'h1234);
        for (int s = 0; s < 4; s++) begin
            fc(16'h1234);
            setv(s, 16'h0);
        end
        fc(16'h1234);
        setv(2, 16'h0abc);
        @(posedge aclk);
        external_processor_mode <= 1;
        fc(16'h0abc);
        axr(`IDX_STATUS, 2'h0, 32'hf4);
        @(posedge aclk);
        external_processor_mode <= 0;
        fc(16'h0abc);
        axr(`IDX_STATUS, 2'h0, 32'h64);
        axw(`IDX_STATUS, 8'h40, 4'h1, 2'h0);
        axr(`IDX_STATUS, 2'h0, 32'h24);
        axw(`IDX_CTRL, 8'h00, 4'h1, 2'h0);
        en = 0;
        axr(`IDX_CTRL, 2'h0, 32'h0);
        fc(16'h0abc);
        axw(`IDX_CTRL, 8'hff, 4'h1, 2'h0);
        en = 1;
        axr(`IDX_CTRL, 2'h0, 32'h1);
        fc(16'h0abc);
        axw(16'hff70, 8'h55, 4'he, 2'h0);
        rall();
        for (n = 0; n < 40; n++) begin
            rs = lfsr(rs);
            if (rs[3]) setv(rs[1:0], rs[4] ? mv[rs[6:5]] : rs[31:16]);
            fc(rs[2] ? mv[rs[9:8]] : rs[27:12]);
        end
        @(posedge aclk);
        aresetn <= 0;
        repeat (3) @(posedge aclk);
        aresetn <= 1;
        mv = '{default: 16'h0};
        rall();
        finish_test();
    end
endmodule
`default_nettype wire
